/* banked_data_memory_addressing_tb.sv */
// Self-checking bench for the data memory addressing core.
// Assumes the core model drives all request and peripheral inputs.
`timescale 1ns/1ps
`define CHK(nm, e, s) begin num_checks++; if ((s) !== (e)) begin num_errors++; \
	$display("BAD %s expected %h seen %h", nm, e, s); end end

module banked_data_memory_addressing_tb;
	import bdma_pkg::*;
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        wdt_pd_rst = 1'b0;
	logic        pc_advance = 1'b0;
	bdma_req_t   req;
	logic [7:0]  alu_result, periph_rdata, bank_select, result_holder;
	logic [2:0]  pc_high;
	logic        periph_hit, pc_jump, pc_stall;
	bdma_rsp_t   rsp;
	logic [10:0] pc_jump_target;
	logic [3:0]  eeprom_control;
	int          num_errors = 0;
	int          num_checks = 0;

	initial forever #20 clk = ~clk;
	bdma_cpu_model i_bdma_cpu_model (.clk(clk), .rsp(rsp), .req(req), .alu_result(alu_result),
		.pc_high(pc_high), .periph_rdata(periph_rdata), .periph_hit(periph_hit));
	bdma_core i_bdma_core (.clk(clk), .sys_rst(sys_rst), .wdt_pd_rst(wdt_pd_rst), .req(req),
		.alu_result(alu_result), .pc_high(pc_high), .pc_advance(pc_advance), .periph_rdata(periph_rdata),
		.periph_hit(periph_hit), .rsp(rsp), .bank_select(bank_select), .result_holder(result_holder),
		.pc_jump_target(pc_jump_target), .pc_jump(pc_jump), .pc_stall(pc_stall),
		.eeprom_control(eeprom_control));

	task automatic conclude();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic op(input bdma_op_t o, input logic [7:0] a, input logic [7:0] d, input logic [2:0] b);
		logic [7:0] q;
		i_bdma_cpu_model.xfer(o, a, d, b, q);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		op(BDMA_OP_WRITE, a, d, 3'h0);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] q;
		i_bdma_cpu_model.xfer(BDMA_OP_READ, a, 8'h00, 3'h0, q);
		`CHK($sformatf("read %h", a), e, q)
	endtask

	// --------------------------------------------------------------
	// Main sequence
	// --------------------------------------------------------------
	initial begin
		repeat (8) @(posedge clk);
		@(negedge clk) sys_rst = 1'b0;
		`CHK("bank", 8'h00, bank_select)
		wr(8'h40, 8'ha5);
		wr(8'h7f, 8'h3c);
		rd(8'h40, 8'ha5);
		rd(8'h7f, 8'h3c);
		wr(8'h41, 8'h00);
		op(BDMA_OP_BSET, 8'h41, 8'h00, 3'h3);
		rd(8'h41, 8'h08);
		wr(8'h42, 8'hff);
		op(BDMA_OP_BCLR, 8'h42, 8'h00, 3'h7);
		rd(8'h42, 8'h7f);
		rd(8'h09, 8'h00);
		wr(8'h08, 8'h3c);
		rd(8'h08, 8'h00);
		i_bdma_cpu_model.periph_val = 8'h5a;
		i_bdma_cpu_model.periph_hit = 1'b1;
		rd(8'h0b, 8'h5a);
		i_bdma_cpu_model.periph_hit = 1'b0;
		wr(8'h01, 8'h45);
		wr(8'h00, 8'h77);
		rd(8'h45, 8'h77);
		op(BDMA_OP_BSET, 8'h01, 8'h00, 3'h1);
		rd(8'h01, 8'h47);
		wr(8'h04, 8'hff);
		rd(8'h04, 8'h01);
		wr(8'h40, 8'h11);
		rd(8'h40, 8'h11);
		wr(8'h03, 8'h40);
		wr(8'h02, 8'h0f);
		`CHK("eectl", 4'hf, eeprom_control)
		rd(8'h02, 8'h0f);
		wr(8'h03, 8'h50);
		rd(8'h02, 8'h00);
		wr(8'h01, 8'h40);
		rd(8'h00, 8'h11);
		wr(8'h03, 8'h03);
		rd(8'h02, 8'h03);
		wdt_pd_rst = 1'b1;
		// A bank write landing on the watchdog wake must not move the bank
		wr(8'h04, 8'h00);
		wdt_pd_rst = 1'b0;
		`CHK("bank", 8'h01, bank_select)
		wr(8'h04, 8'h00);
		wr(8'h03, 8'h40);
		rd(8'h02, 8'h11);
		wr(8'h01, 8'h02);
		wr(8'h00, 8'h55);
		rd(8'h00, 8'h00);
		wr(8'h01, 8'h00);
		rd(8'h00, 8'h00);
		i_bdma_cpu_model.alu_result = 8'hc3;
		op(BDMA_OP_ALU, 8'h00, 8'h00, 3'h0);
		`CHK("result", 8'hc3, result_holder)
		i_bdma_cpu_model.to_acc = 1'b1;
		op(BDMA_OP_READ, 8'h41, 8'h00, 3'h0);
		`CHK("result", 8'h08, result_holder)
		op(BDMA_OP_BSET, 8'h41, 8'h00, 3'h0);
		i_bdma_cpu_model.to_acc = 1'b0;
		`CHK("result", 8'h09, result_holder)
		rd(8'h41, 8'h08);
		wr(8'h43, 8'h00);
		i_bdma_cpu_model.pc_high = 3'h5;
		// Second write lands in the dummy cycle and must be dropped
		i_bdma_cpu_model.put(BDMA_OP_WRITE, 8'h06, 8'h9a, 3'h0);
		`CHK("jump", 1'b1, pc_jump)
		`CHK("stall", 1'b1, pc_stall)
		i_bdma_cpu_model.put(BDMA_OP_WRITE, 8'h43, 8'hee, 3'h0);
		`CHK("jump", 1'b0, pc_jump)
		`CHK("stall", 1'b0, pc_stall)
		op(BDMA_OP_NONE, 8'h00, 8'h00, 3'h0);
		`CHK("target", 11'h59a, pc_jump_target)
		rd(8'h43, 8'h00);
		rd(8'h06, 8'h9a);
		pc_advance = 1'b1;
		@(negedge clk) pc_advance = 1'b0;
		rd(8'h06, 8'h9b);
		wr(8'h04, 8'h01);
		sys_rst = 1'b1;
		@(negedge clk) sys_rst = 1'b0;
		`CHK("bank", 8'h00, bank_select)
		conclude();
	end

	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		conclude();
	end
endmodule // banked_data_memory_addressing_tb

bind bdma_core bdma_core_sva i_bdma_core_sva (.clk(clk), .sys_rst(sys_rst), .wdt_pd_rst(wdt_pd_rst),
	.req(req), .alu_result(alu_result), .pc_high(pc_high), .pc_advance(pc_advance),
	.periph_rdata(periph_rdata), .periph_hit(periph_hit), .rsp(rsp), .bank_select(bank_select),
	.result_holder(result_holder), .pc_jump_target(pc_jump_target), .pc_jump(pc_jump),
	.pc_stall(pc_stall), .eeprom_control(eeprom_control));

/* bdma_core.sv */
// Data memory addressing: RAM, core special registers and indirect pairs.
// Assumes the core issues at most one request per cycle and holds off
// while pc_stall is high. Peripheral registers answer on periph_rdata.
// Writes to other special addresses are not forwarded from here.
`timescale 1ns/1ps

module bdma_core
	import bdma_pkg::*;
(
	input  wire logic            clk,
	input  wire logic            sys_rst,
	input  wire logic            wdt_pd_rst,
	input  wire bdma_req_t       req,
	input  wire logic [7:0]      alu_result,
	input  wire logic [2:0]      pc_high,
	input  wire logic            pc_advance,
	input  wire logic [7:0]      periph_rdata,
	input  wire logic            periph_hit,
	output bdma_rsp_t            rsp,
	output logic      [7:0]      bank_select,
	output logic      [7:0]      result_holder,
	output logic      [10:0]     pc_jump_target,
	output logic                 pc_jump,
	output logic                 pc_stall,
	output logic      [3:0]      eeprom_control
);

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	logic [7:0]     ptr0_reg;
	logic [7:0]     ptr1_reg;
	logic           bank_reg;
	logic [7:0]     result_reg;
	logic [7:0]     pcl_reg;
	logic [3:0]     eectl_reg;
	bdma_pc_state_t pc_state_reg;
	bdma_rsp_t      rsp_reg;
	logic           jump_reg;
	logic [10:0]    target_reg;

	// ---------------------------------------------------------------
	// Address resolution
	// ---------------------------------------------------------------
	logic           is_port0;
	logic           is_port1;
	logic           indirect;
	logic [7:0]     eff_addr;
	logic           eff_bank;
	logic           acc_live;
	logic           is_rd;
	logic           is_wr;
	logic           is_bit;

	// Requests in the dummy cycle are dropped, not delayed: the core
	// must not issue one there, as nothing here holds it for later.
	always_comb begin
		is_port0 = (req.addr == BDMA_ADR_PORT0);
		is_port1 = (req.addr == BDMA_ADR_PORT1);
		indirect = is_port0 | is_port1;
		acc_live = (req.op != BDMA_OP_NONE) && !pc_stall;
		if (is_port0) begin
			eff_addr = ptr0_reg;
			eff_bank = 1'b0;
		end else if (is_port1) begin
			eff_addr = ptr1_reg;
			eff_bank = bank_reg;
		end else begin
			eff_addr = req.addr;
			eff_bank = 1'b0;
		end
		is_rd  = acc_live && (req.op == BDMA_OP_READ);
		is_wr  = acc_live && (req.op == BDMA_OP_WRITE);
		is_bit = acc_live && ((req.op == BDMA_OP_BSET) || (req.op == BDMA_OP_BCLR));
	end

	// Pointer naming a port again is a dead end: reads 00H, writes drop
	logic nested;
	logic in_sfr;
	logic in_ram;
	logic in_eectl;

	always_comb begin
		nested   = indirect && ((eff_addr == BDMA_ADR_PORT0) || (eff_addr == BDMA_ADR_PORT1));
		in_sfr   = !nested && (eff_addr <= BDMA_ADR_SFR_END);
		in_ram   = !eff_bank && (eff_addr >= BDMA_ADR_RAM_LO) && (eff_addr <= BDMA_ADR_RAM_HI);
		in_eectl = eff_bank && (eff_addr == BDMA_ADR_EECTL);
	end

	// ---------------------------------------------------------------
	// Current value of the addressed location
	// ---------------------------------------------------------------
	logic [7:0] ram_rdata;
	logic [7:0] cur;

	always_comb begin
		cur = BDMA_ZERO;
		if (in_sfr) begin
			case (eff_addr)
				BDMA_ADR_PTR0:   cur = ptr0_reg;
				BDMA_ADR_PTR1:   cur = ptr1_reg;
				BDMA_ADR_BANK:   cur = {7'h00, bank_reg};
				BDMA_ADR_RESULT: cur = result_reg;
				BDMA_ADR_PCL:    cur = pcl_reg;
				default:         cur = periph_hit ? periph_rdata : BDMA_ZERO;
			endcase
		end else if (in_ram) begin
			cur = ram_rdata;
		end else if (in_eectl) begin
			cur = {4'h0, eectl_reg};
		end
	end

	// Bit operations merge into the current byte
	logic [7:0] bit_mask;
	logic [7:0] new_val;
	logic       do_store;

	always_comb begin
		bit_mask = 8'h01 << req.bit_sel;
		if (req.op == BDMA_OP_BSET) begin
			new_val = cur | bit_mask;
		end else if (req.op == BDMA_OP_BCLR) begin
			new_val = cur & ~bit_mask;
		end else begin
			new_val = req.wdata;
		end
		// Results aimed at the holder never land in the location too
		do_store = (is_wr || is_bit) && !req.to_result && !nested;
	end

	// ---------------------------------------------------------------
	// Special register write strobes
	// ---------------------------------------------------------------
	// Only the core registers live here. Every other special address,
	// protected ones included, takes no write from this block.
	logic           ptr0_we;
	logic           ptr1_we;
	logic           bank_we;
	logic           result_we;

	always_comb begin
		ptr0_we   = 1'b0;
		ptr1_we   = 1'b0;
		bank_we   = 1'b0;
		result_we = 1'b0;
		if (do_store && in_sfr) begin
			case (eff_addr)
				BDMA_ADR_PTR0:   ptr0_we   = 1'b1;
				BDMA_ADR_PTR1:   ptr1_we   = 1'b1;
				BDMA_ADR_BANK:   bank_we   = 1'b1;
				BDMA_ADR_RESULT: result_we = 1'b1;
				default:         result_we = 1'b0;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// General purpose RAM
	// ---------------------------------------------------------------
	// No reset on the array: contents after power up are unknown
	bdma_ram #(
		.DEPTH (BDMA_RAM_DEPTH),
		.AW    (6)
	) u_ram (
		.clk   (clk),
		.wr_en (do_store && in_ram),
		.addr  (eff_addr[5:0]),
		.wdata (new_val),
		.rdata (ram_rdata)
	);

	// ---------------------------------------------------------------
	// Memory pointers
	// ---------------------------------------------------------------
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ptr0_reg <= BDMA_PTR_RST;
			ptr1_reg <= BDMA_PTR_RST;
		end else begin
			if (ptr0_we) begin
				ptr0_reg <= new_val;
			end
			if (ptr1_we) begin
				ptr1_reg <= new_val;
			end
		end
	end

	// ---------------------------------------------------------------
	// Bank selector
	// ---------------------------------------------------------------
	// Watchdog wake from power down keeps the bank, so that reset is
	// synchronous here and simply leaves the bit alone.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			bank_reg <= BDMA_BANK_RST[BDMA_BANK_BIT];
		end else if (wdt_pd_rst) begin
			bank_reg <= bank_reg;
		end else if (bank_we) begin
			bank_reg <= new_val[BDMA_BANK_BIT];
		end
	end

	// ---------------------------------------------------------------
	// Result holder
	// ---------------------------------------------------------------
	// ALU result first, then redirected results, then a plain write
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			result_reg <= BDMA_RESULT_RST;
		end else if (acc_live && (req.op == BDMA_OP_ALU)) begin
			result_reg <= alu_result;
		end else if ((is_wr || is_bit) && req.to_result) begin
			result_reg <= new_val;
		end else if (is_rd && req.to_result) begin
			result_reg <= cur;
		end else if (result_we) begin
			result_reg <= new_val;
		end
	end

	// ---------------------------------------------------------------
	// EEPROM control, bank 1 only
	// ---------------------------------------------------------------
	// Only the low four control bits exist; the rest read as zero
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			eectl_reg <= 4'h0;
		end else if (do_store && in_eectl) begin
			eectl_reg <= new_val[3:0] & BDMA_EECTL_MASK;
		end
	end

	// ---------------------------------------------------------------
	// Program counter low and in-page jump
	// ---------------------------------------------------------------
	logic pcl_write;

	always_comb begin
		pcl_write = do_store && in_sfr && (eff_addr == BDMA_ADR_PCL);
	end

	// Software write beats the core's own step in the same cycle
	logic [7:0] pcl_next;

	always_comb begin
		pcl_next = pcl_reg;
		if (pcl_write) begin
			pcl_next = new_val;
		end else if (pc_advance && !pc_stall) begin
			pcl_next = pcl_reg + 8'h01;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pcl_reg <= BDMA_PC_RST[7:0];
		end else begin
			pcl_reg <= pcl_next;
		end
	end

	// Target keeps the page bits, so the jump never leaves the page
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			jump_reg   <= 1'b0;
			target_reg <= BDMA_PC_RST;
		end else begin
			jump_reg <= pcl_write;
			if (pcl_write) begin
				target_reg <= {pc_high, new_val};
			end
		end
	end

	// One dummy cycle follows each jump through program counter low
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pc_state_reg <= BDMA_PC_RUN;
		end else begin
			case (pc_state_reg)
				BDMA_PC_RUN: begin
					if (pcl_write) begin
						pc_state_reg <= BDMA_PC_DUMMY;
					end
				end
				BDMA_PC_DUMMY: begin
					pc_state_reg <= BDMA_PC_RUN;
				end
				default: begin
					pc_state_reg <= BDMA_PC_RUN;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Read answer
	// ---------------------------------------------------------------
	logic [7:0] rd_data;

	always_comb begin
		rd_data = cur;
		if (nested) begin
			rd_data = BDMA_ZERO;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rsp_reg <= '0;
		end else begin
			rsp_reg.valid <= is_rd;
			if (is_rd) begin
				rsp_reg.rdata <= rd_data;
			end
		end
	end

	// ---------------------------------------------------------------
	// Dummy cycle flag
	// ---------------------------------------------------------------
	// Own flop so the stall output carries no decode into the core
	logic stall_reg;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			stall_reg <= 1'b0;
		end else begin
			stall_reg <= pcl_write && (pc_state_reg == BDMA_PC_RUN);
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign rsp            = rsp_reg;
	assign bank_select    = {7'h00, bank_reg};
	assign result_holder  = result_reg;
	assign pc_jump_target = target_reg;
	assign pc_jump        = jump_reg;
	assign pc_stall       = stall_reg;
	assign eeprom_control = eectl_reg;

endmodule // bdma_core

/* bdma_core_sva.sv */
// Concurrent checks on the ports of the data memory addressing core.
// Assumes one clock domain and single-cycle request levels from the core.
`timescale 1ns/1ps

module bdma_core_sva
	import bdma_pkg::*;
(
	input wire logic        clk,
	input wire logic        sys_rst,
	input wire logic        wdt_pd_rst,
	input wire bdma_req_t   req,
	input wire logic [7:0]  alu_result,
	input wire logic [2:0]  pc_high,
	input wire logic        pc_advance,
	input wire logic [7:0]  periph_rdata,
	input wire logic        periph_hit,
	input wire bdma_rsp_t   rsp,
	input wire logic [7:0]  bank_select,
	input wire logic [7:0]  result_holder,
	input wire logic [10:0] pc_jump_target,
	input wire logic        pc_jump,
	input wire logic        pc_stall,
	input wire logic [3:0]  eeprom_control
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	logic tk;
	// Taken and aimed at the location itself
	assign tk = !pc_stall && !req.to_result;

	bank_upper_a: assert property (bank_select[7:1] == 7'h00)
		else $error("bank select upper bits set");
	read_answer_a: assert property (req.op == BDMA_OP_READ && !pc_stall |=> rsp.valid)
		else $error("read not answered");
	valid_cause_a: assert property (rsp.valid |-> $past(req.op) == BDMA_OP_READ && !$past(pc_stall))
		else $error("answer without read");
	pcl_jump_a: assert property (req.op == BDMA_OP_WRITE && req.addr == BDMA_ADR_PCL && tk
		|=> pc_jump && pc_stall && pc_jump_target == {$past(pc_high), $past(req.wdata)})
		else $error("jump target or pulse wrong");
	stall_once_a: assert property (pc_stall |=> !pc_stall)
		else $error("dummy cycle too long");
	bank_write_a: assert property (req.op == BDMA_OP_WRITE && req.addr == BDMA_ADR_BANK && tk && !wdt_pd_rst
		|=> bank_select[0] == $past(req.wdata[0]))
		else $error("bank bit not written");
	wdt_hold_a: assert property (wdt_pd_rst |=> $stable(bank_select))
		else $error("bank lost on watchdog wake");
	alu_store_a: assert property (req.op == BDMA_OP_ALU && !pc_stall |=> result_holder == $past(alu_result))
		else $error("alu result not held");
	eectl_direct_a: assert property (req.addr == BDMA_ADR_EECTL && req.op != BDMA_OP_NONE
		|=> eeprom_control == $past(eeprom_control))
		else $error("direct access reached bank one");
	unimpl_zero_a: assert property (req.op == BDMA_OP_READ && !pc_stall && req.addr > BDMA_ADR_PCL
		&& req.addr <= BDMA_ADR_SFR_END && !periph_hit |=> rsp.rdata == BDMA_ZERO)
		else $error("unused location not zero");
endmodule // bdma_core_sva

/* bdma_cpu_model.sv */
// Processor core model: one data memory request at a time, plus peripheral bus.
// Assumes its tasks are entered at a falling clock edge.
`timescale 1ns/1ps

module bdma_cpu_model
	import bdma_pkg::*;
(
	input  wire logic      clk,
	input  wire bdma_rsp_t rsp,
	output bdma_req_t      req,
	output logic [7:0]     alu_result,
	output logic [2:0]     pc_high,
	output logic [7:0]     periph_rdata,
	output logic           periph_hit
);
	logic [7:0] periph_val = 8'h00;
	logic [7:0] noise      = 8'h00;
	logic       to_acc     = 1'b0;
	// Undecoded peripheral bus never shows a stale byte
	assign periph_rdata = periph_hit ? periph_val : noise;
	always @(posedge clk) noise <= ~noise + 8'h01;
	initial begin
		req = '{op: BDMA_OP_NONE, addr: 8'h00, wdata: 8'h00, bit_sel: 3'h0, to_result: 1'b0};
		alu_result = 8'h00;
		pc_high = 3'h0;
		periph_hit = 1'b0;
	end
	// One-cycle request level; callers may chain these back to back
	task automatic put(input bdma_op_t o, input logic [7:0] a, input logic [7:0] d, input logic [2:0] b);
		req = '{op: o, addr: a, wdata: d, bit_sel: b, to_result: to_acc};
		@(posedge clk);
		@(negedge clk);
	endtask
	task automatic xfer(input bdma_op_t o, input logic [7:0] a, input logic [7:0] d, input logic [2:0] b,
		output logic [7:0] q);
		put(o, a, d, b);
		q = (rsp.valid === 1'b1) ? rsp.rdata : 8'hxx;
		req.op = BDMA_OP_NONE;
		@(negedge clk);
	endtask
endmodule // bdma_cpu_model

/* bdma_pkg.sv */
// Constants and carrier types for the banked data memory addressing block.
// Assumes a single 25 MHz system clock domain shared with the processor core.
//
// Behaviour
// - 64 bytes of general RAM at 40H to 7FH of bank 0, read and write.
// - Bit set and clear on RAM change only the addressed bit.
// - Reads of unimplemented special-function locations return 00H.
// - Special area 00H to 3FH maps alike in both banks, core at 00H-06H.
// - Protected special registers are read only; writes leave them unchanged.
// - Indirect ports touch no register; access goes to the pointer's location.
// - Pair 0 always reaches bank 0; pair 1 reaches the selected bank.
// - Indirect access aimed at an indirect port reads 00H, writes nothing.
// - Both pointers are real registers: read, write, increment, bit operations; no increment op here, ALU results go only to the result holder.
// - Direct addressing always reaches bank 0 whatever the bank selector holds.
// - Bank selector holds one writable bit 0; bits 7 to 1 read zero.
// - Every reset clears the bank selector, except watchdog reset in power down.
// - ALU results land in the result holder; no register-to-register moves.
// - Writing program counter low replaces only the low 8 counter bits.
// - Such a jump inserts one dummy instruction cycle.
// - The EEPROM control register at 40H exists only in bank 1.
package bdma_pkg;

	localparam int          BDMA_AW          = 8;
	localparam int          BDMA_DW          = 8;
	localparam int          BDMA_PCW         = 11;
	localparam int          BDMA_RAM_DEPTH   = 64;

	localparam logic [7:0]  BDMA_ADR_PORT0   = 8'h00;
	localparam logic [7:0]  BDMA_ADR_PTR0    = 8'h01;
	localparam logic [7:0]  BDMA_ADR_PORT1   = 8'h02;
	localparam logic [7:0]  BDMA_ADR_PTR1    = 8'h03;
	localparam logic [7:0]  BDMA_ADR_BANK    = 8'h04;
	localparam logic [7:0]  BDMA_ADR_RESULT  = 8'h05;
	localparam logic [7:0]  BDMA_ADR_PCL     = 8'h06;
	localparam logic [7:0]  BDMA_ADR_SFR_END = 8'h3f;
	localparam logic [7:0]  BDMA_ADR_RAM_LO  = 8'h40;
	localparam logic [7:0]  BDMA_ADR_RAM_HI  = 8'h7f;
	localparam logic [7:0]  BDMA_ADR_EECTL   = 8'h40;

	localparam int          BDMA_BANK_BIT    = 0;
	localparam logic [7:0]  BDMA_BANK_RST    = 8'h00;
	localparam logic [7:0]  BDMA_ZERO        = 8'h00;
	localparam logic [7:0]  BDMA_PTR_RST     = 8'h00;
	localparam logic [7:0]  BDMA_RESULT_RST  = 8'h00;
	localparam logic [10:0] BDMA_PC_RST      = 11'h000;
	localparam logic [3:0]  BDMA_EECTL_MASK  = 4'hf;
	localparam int          BDMA_DUMMY_CYC   = 1;

	// Operation the core asks for on one data memory location
	typedef enum logic [5:0] {
		BDMA_OP_NONE  = 6'b00_0001,
		BDMA_OP_READ  = 6'b00_0010,
		BDMA_OP_WRITE = 6'b00_0100,
		BDMA_OP_BSET  = 6'b00_1000,
		BDMA_OP_BCLR  = 6'b01_0000,
		BDMA_OP_ALU   = 6'b10_0000
	} bdma_op_t;

	typedef struct packed {
		bdma_op_t           op;
		logic [7:0]         addr;
		logic [7:0]         wdata;
		logic [2:0]         bit_sel;
		logic               to_result;
	} bdma_req_t;

	typedef struct packed {
		logic               valid;
		logic [7:0]         rdata;
	} bdma_rsp_t;

	typedef enum logic [1:0] {
		BDMA_PC_RUN   = 2'b01,
		BDMA_PC_DUMMY = 2'b10
	} bdma_pc_state_t;

endpackage : bdma_pkg

/* bdma_ram.sv */
// General purpose RAM array with synchronous whole-byte writes and combinational read.
// Assumes the caller resolves addressing and bit merges before writing.
`timescale 1ns/1ps

module bdma_ram
	import bdma_pkg::*;
#(
	parameter int DEPTH = BDMA_RAM_DEPTH,
	parameter int AW    = 6
) (
	input  wire logic          clk,
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] addr,
	input  wire logic [7:0]    wdata,
	output logic      [7:0]    rdata
);

	logic [7:0] mem [DEPTH];

	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[addr] <= wdata;
		end
	end

	// Read-through so bit operations see the current byte
	always_comb begin
		rdata = mem[addr];
	end

endmodule // bdma_ram
